// file: src/cie_pkg.sv
// constants for the codec event flags and system enable block
package cie_pkg;
    // register offsets
    localparam logic [7:0] OFF_FLAGS = 8'h00;
    localparam logic [7:0] OFF_MASK = 8'h01;
    localparam logic [7:0] OFF_SRC_EN = 8'h02;
    localparam logic [7:0] OFF_LEFT_DETECTION_CONTROL = 8'h0D;
    localparam logic [7:0] OFF_SUBSYS = 8'h32;
    localparam logic [7:0] OFF_ACTION = 8'h33;
    // flag bit positions
    localparam int BIT_GAIN = 6;
    localparam int BIT_THERMAL_WARNING = 5;
    localparam int BIT_MAIN_CLOCK_READY = 4;
    localparam int BIT_CLIP = 3;
    localparam int BIT_OC = 2;
    localparam int BIT_LEFT_MIC_LEVEL = 1;
    localparam int BIT_RIGHT_MIC_LEVEL = 0;
    // subsystem enable bit positions
    localparam int BIT_AUDIO = 5;
    localparam int BIT_LINE = 4;
    localparam int BIT_AMP = 3;
    // left detection control: enable position
    localparam int BIT_LDEN = 0;
    // writable masks
    localparam logic [7:0] FLAG_MASK = 8'h7F;
    localparam logic [7:0] SRC_EN_MASK = 8'h4B;
    localparam logic [7:0] SUBSYS_MASK = 8'h3B;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // action codes
    localparam logic [7:0] ACT_STOP = 8'h00;
    localparam logic [7:0] ACT_START = 8'h01;
    localparam logic [7:0] ACT_SOFT_RESET = 8'hFF;
endpackage

// file: src/cie_top.sv
// event flags, interrupt mask, event enables and subsystem enables
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module cie_top (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // event inputs from analog and detector blocks (asynchronous levels/pulses)
    input wire logic gain_ramp_done,
    input wire logic thermal_warning,
    input wire logic main_clock_active,
    input wire logic output_clipping,
    input wire logic output_overcurrent,
    input wire logic left_mic_level,
    input wire logic right_mic_level,
    // outputs
    output logic irq_request_n,
    output logic main_clock_run,
    output logic audio_port_enable,
    output logic line_output_enable,
    output logic speaker_amp_enable,
    output logic left_mic_enable,
    output logic right_mic_enable
);
    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic [6:0] prev;
        logic [7:0] flags;
        logic [7:0] mask;
        logic [7:0] src_en;
        logic [7:0] left_detection_control;
        logic [7:0] subsys;
        logic run;
        logic irq_n;
        logic [7:0] rdata;
    } cie_state_t;

    cie_state_t st_q;
    cie_state_t st_d;
    logic [6:0] ev_in;
    logic [6:0] ev_rise;
    logic [7:0] ev_set;
    logic [7:0] wflags;
    logic [7:0] wsrc;
    logic amp_block;

    assign ev_in = {gain_ramp_done, thermal_warning, main_clock_active, output_clipping,
                    output_overcurrent, left_mic_level, right_mic_level};

    always_comb begin
        st_d = st_q;
        // two-stage synchroniser; only the second stage feeds the edge detector
        st_d.s1 = ev_in;
        st_d.s2 = st_q.s1;
        st_d.prev = st_q.s2;
        ev_rise = st_q.s2 & ~st_q.prev;
        ev_set = 8'h00;
        ev_set[cie_pkg::BIT_MAIN_CLOCK_READY] = ev_rise[cie_pkg::BIT_MAIN_CLOCK_READY];
        ev_set[cie_pkg::BIT_THERMAL_WARNING] = ev_rise[cie_pkg::BIT_THERMAL_WARNING];
        ev_set[cie_pkg::BIT_OC] = ev_rise[cie_pkg::BIT_OC];
        // enable-gated events
        ev_set[cie_pkg::BIT_GAIN] = ev_rise[cie_pkg::BIT_GAIN] & st_q.src_en[cie_pkg::BIT_GAIN];
        ev_set[cie_pkg::BIT_CLIP] = ev_rise[cie_pkg::BIT_CLIP]
                                    & st_q.src_en[cie_pkg::BIT_CLIP];
        ev_set[cie_pkg::BIT_LEFT_MIC_LEVEL] = ev_rise[cie_pkg::BIT_LEFT_MIC_LEVEL]
                                    & st_q.left_detection_control[cie_pkg::BIT_LDEN];
        ev_set[cie_pkg::BIT_RIGHT_MIC_LEVEL] = ev_rise[cie_pkg::BIT_RIGHT_MIC_LEVEL]
                                    & st_q.src_en[cie_pkg::BIT_RIGHT_MIC_LEVEL];
        // read clear first, new events win over it
        wflags = st_q.flags;
        if (reg_rd && reg_addr == cie_pkg::OFF_FLAGS) begin
            wflags = 8'h00;
        end
        st_d.flags = (wflags | ev_set) & cie_pkg::FLAG_MASK;
        st_d.rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                cie_pkg::OFF_FLAGS: st_d.rdata = st_q.flags;
                cie_pkg::OFF_MASK: st_d.rdata = st_q.mask;
                cie_pkg::OFF_SRC_EN: begin
                    st_d.rdata = st_q.src_en;
                    st_d.rdata[cie_pkg::BIT_LEFT_MIC_LEVEL] = st_q.left_detection_control[cie_pkg::BIT_LDEN];
                end
                cie_pkg::OFF_LEFT_DETECTION_CONTROL: st_d.rdata = st_q.left_detection_control;
                cie_pkg::OFF_SUBSYS: st_d.rdata = st_q.subsys;
                default: st_d.rdata = 8'h00;
            endcase
        end
        amp_block = st_q.flags[cie_pkg::BIT_THERMAL_WARNING] | st_q.flags[cie_pkg::BIT_OC];
        wsrc = st_q.src_en;
        wsrc[cie_pkg::BIT_LEFT_MIC_LEVEL] = st_q.left_detection_control[cie_pkg::BIT_LDEN];
        if (reg_wr) begin
            case (reg_addr)
                cie_pkg::OFF_MASK: st_d.mask = reg_wdata & cie_pkg::FLAG_MASK;
                cie_pkg::OFF_SRC_EN: begin
                    // a set is refused while the matching flag is still pending
                    wsrc = reg_wdata & cie_pkg::SRC_EN_MASK;
                    wsrc = wsrc & ~(st_q.flags & cie_pkg::SRC_EN_MASK & ~st_q.src_en
                                    & ~{6'h00, st_q.left_detection_control[cie_pkg::BIT_LDEN], 1'b0});
                end
                cie_pkg::OFF_LEFT_DETECTION_CONTROL: begin
                    wsrc[cie_pkg::BIT_LEFT_MIC_LEVEL] = reg_wdata[cie_pkg::BIT_LDEN]
                        & ~(st_q.flags[cie_pkg::BIT_LEFT_MIC_LEVEL] & ~wsrc[cie_pkg::BIT_LEFT_MIC_LEVEL]);
                    st_d.left_detection_control = reg_wdata;
                end
                cie_pkg::OFF_SUBSYS: begin
                    st_d.subsys = reg_wdata & cie_pkg::SUBSYS_MASK;
                    if (amp_block && !st_q.subsys[cie_pkg::BIT_AMP]) begin
                        st_d.subsys[cie_pkg::BIT_AMP] = 1'b0;
                    end
                end
                cie_pkg::OFF_ACTION: begin
                    if (reg_wdata == cie_pkg::ACT_START) begin
                        st_d.run = 1'b1;
                    end else if (reg_wdata == cie_pkg::ACT_STOP) begin
                        st_d.run = 1'b0;
                    end
                end
                default: st_d.run = st_d.run;
            endcase
        end
        // events self-clear their source enables
        wsrc = wsrc & ~(ev_set & cie_pkg::SRC_EN_MASK);
        st_d.src_en = wsrc & cie_pkg::SRC_EN_MASK;
        st_d.left_detection_control[cie_pkg::BIT_LDEN] = wsrc[cie_pkg::BIT_LEFT_MIC_LEVEL];
        if (ev_set[cie_pkg::BIT_THERMAL_WARNING] || ev_set[cie_pkg::BIT_OC]) begin
            st_d.subsys[cie_pkg::BIT_AMP] = 1'b0;
        end
        st_d.irq_n = ~|(st_d.flags & st_d.mask);
        if (reg_wr && reg_addr == cie_pkg::OFF_ACTION && reg_wdata == cie_pkg::ACT_SOFT_RESET) begin
            // soft reset returns registers only; synchronisers keep tracking
            st_d.flags = cie_pkg::RST_REG;
            st_d.mask = cie_pkg::RST_REG;
            st_d.src_en = cie_pkg::RST_REG;
            st_d.left_detection_control = cie_pkg::RST_REG;
            st_d.subsys = cie_pkg::RST_REG;
            st_d.run = 1'b0;
            st_d.irq_n = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_q <= '0;
            st_q.irq_n <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign irq_request_n = st_q.irq_n;
    assign main_clock_run = st_q.run;
    assign audio_port_enable = st_q.subsys[cie_pkg::BIT_AUDIO];
    assign line_output_enable = st_q.subsys[cie_pkg::BIT_LINE];
    assign speaker_amp_enable = st_q.subsys[cie_pkg::BIT_AMP];
    assign left_mic_enable = st_q.subsys[cie_pkg::BIT_LEFT_MIC_LEVEL];
    assign right_mic_enable = st_q.subsys[cie_pkg::BIT_RIGHT_MIC_LEVEL];

    a_irq_follows: assert property (@(posedge clock) disable iff (rst)
        (|(st_q.flags & st_q.mask)) |-> !irq_request_n)
        else $error("irq not asserted for pending flag");
    a_irq_release: assert property (@(posedge clock) disable iff (rst)
        !(|(st_q.flags & st_q.mask)) |-> irq_request_n)
        else $error("irq asserted with nothing pending");
    a_read_clears: assert property (@(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == cie_pkg::OFF_FLAGS)
        |=> ((st_q.flags & ~$past(ev_set)) == 8'h00))
        else $error("flags not cleared by read");
    a_bit7_zero: assert property (@(posedge clock) disable iff (rst)
        !st_q.flags[7] && !st_q.mask[7])
        else $error("bit seven set");
    a_amp_off: assert property (@(posedge clock) disable iff (rst)
        (ev_set[cie_pkg::BIT_THERMAL_WARNING] || ev_set[cie_pkg::BIT_OC]) |=> !speaker_amp_enable)
        else $error("amp not shut off");
    a_amp_refuse: assert property (@(posedge clock) disable iff (rst)
        (!speaker_amp_enable && amp_block) |=> !speaker_amp_enable)
        else $error("amp enabled while fault pending");
    a_gain_selfclr: assert property (@(posedge clock) disable iff (rst)
        ev_set[cie_pkg::BIT_GAIN] |=> !st_q.src_en[cie_pkg::BIT_GAIN])
        else $error("gain enable not self cleared");
    a_clip_gate: assert property (@(posedge clock) disable iff (rst)
        (ev_rise[cie_pkg::BIT_CLIP] && !st_q.src_en[cie_pkg::BIT_CLIP]
         && !st_q.flags[cie_pkg::BIT_CLIP] && !(reg_wr && reg_addr == cie_pkg::OFF_ACTION))
        |=> !st_q.flags[cie_pkg::BIT_CLIP])
        else $error("clip flag set while disabled");
    a_event_wins: assert property (@(posedge clock) disable iff (rst)
        (ev_set[cie_pkg::BIT_MAIN_CLOCK_READY] && !(reg_wr && reg_addr == cie_pkg::OFF_ACTION))
        |=> st_q.flags[cie_pkg::BIT_MAIN_CLOCK_READY])
        else $error("event lost");
    a_cmd_readzero: assert property (@(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == cie_pkg::OFF_ACTION) |=> reg_rdata == 8'h00)
        else $error("action register not zero");
    c_irq: cover property (@(posedge clock) disable iff (rst) $fell(irq_request_n));
    c_amp_trip: cover property (@(posedge clock) disable iff (rst) $fell(speaker_amp_enable));
    c_read_clear: cover property (@(posedge clock) disable iff (rst)
        (reg_rd && reg_addr == cie_pkg::OFF_FLAGS && st_q.flags != 8'h00));
    c_src_selfclr: cover property (@(posedge clock) disable iff (rst)
        ev_set[cie_pkg::BIT_CLIP]);
    c_src_refused: cover property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_SRC_EN && (st_q.flags & cie_pkg::SRC_EN_MASK) != 8'h00));

    // helper terms for the checks below
    logic flag_rd;
    logic soft_hit;
    assign flag_rd = reg_rd && reg_addr == cie_pkg::OFF_FLAGS;
    assign soft_hit = reg_wr && reg_addr == cie_pkg::OFF_ACTION && reg_wdata == cie_pkg::ACT_SOFT_RESET;

    // ungated events reach their flags unless a soft reset lands in the same cycle
    a_main_clock_ready_set: assert property (@(posedge clock) disable iff (rst)
        (ev_rise[cie_pkg::BIT_MAIN_CLOCK_READY] && !soft_hit)
        |=> st_q.flags[cie_pkg::BIT_MAIN_CLOCK_READY])
        else $error("clock ready flag missed");
    a_thermal_warning_set: assert property (@(posedge clock) disable iff (rst)
        (ev_rise[cie_pkg::BIT_THERMAL_WARNING] && !soft_hit)
        |=> st_q.flags[cie_pkg::BIT_THERMAL_WARNING])
        else $error("thermal flag missed");
    a_thermal_warning_amp: assert property (@(posedge clock) disable iff (rst)
        ev_rise[cie_pkg::BIT_THERMAL_WARNING]
        |=> !speaker_amp_enable)
        else $error("amp left on after thermal event");
    a_oc_set: assert property (@(posedge clock) disable iff (rst)
        (ev_rise[cie_pkg::BIT_OC] && !soft_hit)
        |=> st_q.flags[cie_pkg::BIT_OC])
        else $error("overcurrent flag missed");
    a_oc_amp: assert property (@(posedge clock) disable iff (rst)
        ev_rise[cie_pkg::BIT_OC]
        |=> !speaker_amp_enable)
        else $error("amp left on after overcurrent");

    // gated events and their enables
    a_left_mic_level_set: assert property (@(posedge clock) disable iff (rst)
        (ev_rise[cie_pkg::BIT_LEFT_MIC_LEVEL] && st_q.left_detection_control[cie_pkg::BIT_LDEN] && !soft_hit)
        |=> st_q.flags[cie_pkg::BIT_LEFT_MIC_LEVEL])
        else $error("left mic flag missed");
    a_right_mic_level_set: assert property (@(posedge clock) disable iff (rst)
        (ev_rise[cie_pkg::BIT_RIGHT_MIC_LEVEL] && st_q.src_en[cie_pkg::BIT_RIGHT_MIC_LEVEL] && !soft_hit)
        |=> st_q.flags[cie_pkg::BIT_RIGHT_MIC_LEVEL])
        else $error("right mic flag missed");
    a_right_mic_level_gate: assert property (@(posedge clock) disable iff (rst)
        (ev_rise[cie_pkg::BIT_RIGHT_MIC_LEVEL] && !st_q.src_en[cie_pkg::BIT_RIGHT_MIC_LEVEL] && !st_q.flags[0])
        |=> !st_q.flags[cie_pkg::BIT_RIGHT_MIC_LEVEL])
        else $error("right mic flag set while disabled");
    a_left_mic_level_gate: assert property (@(posedge clock) disable iff (rst)
        (ev_rise[cie_pkg::BIT_LEFT_MIC_LEVEL] && !st_q.left_detection_control[cie_pkg::BIT_LDEN] && !st_q.flags[1])
        |=> !st_q.flags[cie_pkg::BIT_LEFT_MIC_LEVEL])
        else $error("left mic flag set while disabled");
    a_gain_gate: assert property (@(posedge clock) disable iff (rst)
        (ev_rise[cie_pkg::BIT_GAIN] && !st_q.src_en[cie_pkg::BIT_GAIN] && !st_q.flags[6])
        |=> !st_q.flags[cie_pkg::BIT_GAIN])
        else $error("gain flag set while disabled");

    // read and clear behaviour
    a_flags_hold: assert property (@(posedge clock) disable iff (rst)
        (!flag_rd && !soft_hit)
        |=> (($past(st_q.flags) & ~st_q.flags) == 8'h00))
        else $error("flag dropped without a read");
    a_flags_read: assert property (@(posedge clock) disable iff (rst)
        flag_rd
        |=> reg_rdata == $past(st_q.flags))
        else $error("flag read returned wrong value");
    a_rdata_idle: assert property (@(posedge clock) disable iff (rst)
        !reg_rd
        |=> reg_rdata == 8'h00)
        else $error("read data not idle");

    // self clearing of enables
    a_clip_selfclr: assert property (@(posedge clock) disable iff (rst)
        ev_set[cie_pkg::BIT_CLIP]
        |=> !st_q.src_en[cie_pkg::BIT_CLIP])
        else $error("clip enable not self cleared");
    a_left_mic_level_selfclr: assert property (@(posedge clock) disable iff (rst)
        ev_set[cie_pkg::BIT_LEFT_MIC_LEVEL]
        |=> !st_q.left_detection_control[cie_pkg::BIT_LDEN])
        else $error("left mic enable not self cleared");
    a_right_mic_level_selfclr: assert property (@(posedge clock) disable iff (rst)
        ev_set[cie_pkg::BIT_RIGHT_MIC_LEVEL]
        |=> !st_q.src_en[cie_pkg::BIT_RIGHT_MIC_LEVEL])
        else $error("right mic enable not self cleared");

    // refused re-enables while the flag is pending
    a_gain_refuse: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_SRC_EN && st_q.flags[6] && !st_q.src_en[6])
        |=> !st_q.src_en[cie_pkg::BIT_GAIN])
        else $error("gain enable set while flag pending");
    a_clip_refuse: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_SRC_EN && st_q.flags[3] && !st_q.src_en[3])
        |=> !st_q.src_en[cie_pkg::BIT_CLIP])
        else $error("clip enable set while flag pending");
    a_right_mic_level_refuse: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_SRC_EN && st_q.flags[0] && !st_q.src_en[0])
        |=> !st_q.src_en[cie_pkg::BIT_RIGHT_MIC_LEVEL])
        else $error("right mic enable set while flag pending");
    a_left_mic_level_refuse: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_SRC_EN && st_q.flags[1] && !st_q.left_detection_control[0])
        |=> !st_q.left_detection_control[cie_pkg::BIT_LDEN])
        else $error("left mic enable set while flag pending");
    a_left_mic_level_ldref: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_LEFT_DETECTION_CONTROL && st_q.flags[1] && !st_q.left_detection_control[0])
        |=> !st_q.left_detection_control[cie_pkg::BIT_LDEN])
        else $error("detector enable set while flag pending");

    // register layout and shared storage
    a_left_mic_level_same: assert property (@(posedge clock) disable iff (rst)
        st_q.src_en[cie_pkg::BIT_LEFT_MIC_LEVEL] == st_q.left_detection_control[cie_pkg::BIT_LDEN])
        else $error("left mic enable copies differ");
    a_src_layout: assert property (@(posedge clock) disable iff (rst)
        (st_q.src_en & ~cie_pkg::SRC_EN_MASK) == 8'h00)
        else $error("event enable spare bit set");
    a_sub_layout: assert property (@(posedge clock) disable iff (rst)
        (st_q.subsys & ~cie_pkg::SUBSYS_MASK) == 8'h00)
        else $error("subsystem spare bit set");
    a_mask_layout: assert property (@(posedge clock) disable iff (rst)
        (st_q.mask & ~cie_pkg::FLAG_MASK) == 8'h00)
        else $error("mask spare bit set");
    a_sub_pins: assert property (@(posedge clock) disable iff (rst)
        audio_port_enable == st_q.subsys[cie_pkg::BIT_AUDIO]
        && line_output_enable == st_q.subsys[cie_pkg::BIT_LINE]
        && left_mic_enable == st_q.subsys[cie_pkg::BIT_LEFT_MIC_LEVEL]
        && right_mic_enable == st_q.subsys[cie_pkg::BIT_RIGHT_MIC_LEVEL])
        else $error("subsystem pins differ from register");
    a_mask_write: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_MASK)
        |=> st_q.mask == ($past(reg_wdata) & cie_pkg::FLAG_MASK))
        else $error("mask write lost");
    a_irq_masked: assert property (@(posedge clock) disable iff (rst)
        ((st_q.flags & ~st_q.mask) != 8'h00 && (st_q.flags & st_q.mask) == 8'h00)
        |-> irq_request_n)
        else $error("masked flag drove irq");

    // action codes
    a_start_run: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_ACTION && reg_wdata == cie_pkg::ACT_START)
        |=> main_clock_run)
        else $error("start code ignored");
    a_stop_run: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_ACTION && reg_wdata == cie_pkg::ACT_STOP)
        |=> !main_clock_run)
        else $error("stop code ignored");
    a_soft_clear: assert property (@(posedge clock) disable iff (rst)
        soft_hit
        |=> (st_q.flags | st_q.mask | st_q.src_en | st_q.subsys) == 8'h00 && !main_clock_run)
        else $error("soft reset incomplete");
    a_action_keep: assert property (@(posedge clock) disable iff (rst)
        (reg_wr && reg_addr == cie_pkg::OFF_ACTION && reg_wdata != cie_pkg::ACT_START
         && reg_wdata != cie_pkg::ACT_STOP && reg_wdata != cie_pkg::ACT_SOFT_RESET)
        |=> main_clock_run == $past(main_clock_run))
        else $error("reserved code changed run state");
endmodule
`default_nettype wire

// file: tb/cie_event_src.sv
// far-side event source: turns one-cycle fire requests into held levels
`timescale 1ns/1ps
`default_nettype none
module cie_event_src (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // requests in, event levels out
    input wire logic [6:0] fire,
    output logic [6:0] ev
);
    logic [6:0] d1_q;
    logic [6:0] d2_q;
    logic [6:0] d3_q;
    // held three clocks so the two-flop synchroniser cannot miss the edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            d1_q <= 7'h00;
            d2_q <= 7'h00;
            d3_q <= 7'h00;
        end else begin
            d1_q <= fire;
            d2_q <= d1_q;
            d3_q <= d2_q;
        end
    end
    assign ev = d1_q | d2_q | d3_q;
endmodule
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the event flag and subsystem enable block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock, rst, reg_wr, reg_rd, irq_request_n, main_clock_run;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic audio_port_enable, line_output_enable, speaker_amp_enable;
    logic left_mic_enable, right_mic_enable;
    logic [6:0] fire, ev;
    int num_errors = 0;
    int check_count = 0;
    cie_event_src cie_event_src_i (.clock(clock), .rst(rst), .fire(fire), .ev(ev));
    cie_top cie_top_i (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .gain_ramp_done(ev[6]), .thermal_warning(ev[5]), .main_clock_active(ev[4]),
        .output_clipping(ev[3]), .output_overcurrent(ev[2]), .left_mic_level(ev[1]),
        .right_mic_level(ev[0]), .irq_request_n(irq_request_n),
        .main_clock_run(main_clock_run), .audio_port_enable(audio_port_enable),
        .line_output_enable(line_output_enable), .speaker_amp_enable(speaker_amp_enable),
        .left_mic_enable(left_mic_enable), .right_mic_enable(right_mic_enable));
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: byte %h wanted %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: pin %b wanted %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk8(reg_rdata, exp);
    endtask
    // sync plus edge detect needs about four clocks; eight leaves margin
    task automatic shoot(input logic [6:0] bits);
        @(posedge clock);
        fire <= bits;
        @(posedge clock);
        fire <= 7'h00;
        repeat (8) @(posedge clock);
        #1;
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        close_out();
    end
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        fire = 7'h00;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        rdc(8'h00, 8'h00);
        chk1(irq_request_n, 1'b1);
        rdc(8'h02, 8'h00);
        rdc(8'h32, 8'h00);
        rdc(8'h10, 8'h00);
        wr(8'h33, 8'h01);
        rdc(8'h33, 8'h00);
        chk1(main_clock_run, 1'b1);
        $display("test reset and start done");
        wr(8'h01, 8'hFF);
        rdc(8'h01, 8'h7F);
        shoot(7'h10);
        chk1(irq_request_n, 1'b0);
        rdc(8'h00, 8'h10);
        rdc(8'h00, 8'h00);
        chk1(irq_request_n, 1'b1);
        wr(8'h01, 8'h00);
        shoot(7'h20);
        chk1(irq_request_n, 1'b1);
        rdc(8'h00, 8'h20);
        $display("test irq and mask done");
        wr(8'h32, 8'hFF);
        rdc(8'h32, 8'h3B);
        chk1(speaker_amp_enable, 1'b1);
        chk1(audio_port_enable, 1'b1);
        chk1(line_output_enable, 1'b1);
        chk1(left_mic_enable, 1'b1);
        chk1(right_mic_enable, 1'b1);
        shoot(7'h04);
        rdc(8'h32, 8'h33);
        chk1(speaker_amp_enable, 1'b0);
        wr(8'h32, 8'h3B);
        rdc(8'h32, 8'h33);
        rdc(8'h00, 8'h04);
        wr(8'h32, 8'h3B);
        rdc(8'h32, 8'h3B);
        shoot(7'h20);
        rdc(8'h32, 8'h33);
        rdc(8'h00, 8'h20);
        $display("test amplifier shutdown done");
        wr(8'h02, 8'hFF);
        rdc(8'h02, 8'h4B);
        shoot(7'h4B);
        rdc(8'h02, 8'h00);
        wr(8'h02, 8'h4B);
        rdc(8'h02, 8'h00);
        rdc(8'h00, 8'h4B);
        wr(8'h02, 8'h4B);
        rdc(8'h02, 8'h4B);
        wr(8'h02, 8'h00);
        shoot(7'h4B);
        rdc(8'h00, 8'h00);
        wr(8'h0D, 8'h01);
        rdc(8'h02, 8'h02);
        $display("test event enables done");
        wr(8'h33, 8'h00);
        chk1(main_clock_run, 1'b0);
        rdc(8'h33, 8'h00);
        chk1(main_clock_run, 1'b0);
        wr(8'h33, 8'h01);
        wr(8'h33, 8'h02);
        wr(8'h01, 8'h7F);
        chk1(main_clock_run, 1'b1);
        wr(8'h33, 8'hFF);
        rdc(8'h01, 8'h00);
        rdc(8'h02, 8'h00);
        rdc(8'h32, 8'h00);
        chk1(main_clock_run, 1'b0);
        $display("test action codes done");
        close_out();
    end
endmodule
`default_nettype wire
